// *** hw/kbhp_host_port.sv ***
// host port, flags, interrupt gating, pins and power-down of the keyboard controller
`timescale 1ns/10ps
`default_nettype none
module kbhp_host_port #(
   parameter int BUF_W = 9
) (
   input wire logic clk, // 125 MHz clock
   input wire logic rst, // synchronous reset, active high
   input wire logic host_sel_n, // decoded port select, qualified by AEN
   input wire logic host_a2, // host address line 2
   input wire logic host_rd_n, // host read strobe
   input wire logic host_wr_n, // host write strobe
   input wire logic [7:0] host_wdata, // host data bus in
   output logic [7:0] host_rdata, // host data bus out
   output logic host_rdata_oe_n, // host bus drive, low drives
   output logic kbd_irq_out, // keyboard interrupt
   output logic aux_irq_out, // auxiliary interrupt
   input wire logic core_data_wr, // core writes the data register
   input wire logic core_data_rd, // core reads the data register
   input wire logic core_sts_wr, // core writes the status register
   input wire logic [7:0] core_wdata, // core write data
   output logic [7:0] core_input_buffer, // byte from host, registered
   output logic [7:0] core_status, // status as the core sees it
   input wire logic core_en_flags, // flag mode enable instruction
   input wire logic [7:0] core_port2, // core port 2 latch
   input wire logic core_halt, // halt instruction executed
   input wire logic core_stop, // stop instruction executed
   input wire logic ibf_irq_en, // core IN_BUF_FULL interrupt enable
   input wire logic tmr_irq_en, // core timer interrupt enable
   input wire logic tmr_overflow, // timer/counter overflow event
   output logic core_irq_ibf, // core interrupt from input buffer
   output logic core_irq_tmr, // core interrupt from timer
   output logic alu_clk_en, // ALU clock runs
   output logic osc_en, // oscillator driver enabled
   output logic wake_call, // wake pulse, call interrupt routine
   output logic wake_next, // wake pulse, continue with next instruction
   output logic core_restart, // pulse after reset, start at address below
   output logic [10:0] core_start_addr, // program start address
   input wire logic gp_route_gate, // route address gate to general pin
   input wire logic gp_user_level, // general pin level when not routed
   output logic general_out_pin, // general purpose output
   output logic addr_line_gate, // gate-A20 level
   input wire logic kbd_clk_pin_in, // keyboard clock pin level
   output logic kbd_clk_pin_out, // keyboard clock pin drive value
   output logic kbd_clk_pin_oe_n, // keyboard clock pin pull-down, low drives
   input wire logic kbd_data_pin_in, // keyboard data pin level
   output logic kbd_data_pin_out, // keyboard data pin drive value
   output logic kbd_data_pin_oe_n, // keyboard data pin pull-down, low drives
   input wire logic mouse_clk_pin_in, // mouse clock pin level
   output logic mouse_clk_pin_out, // mouse clock pin drive value
   output logic mouse_clk_pin_oe_n, // mouse clock pin pull-down, low drives
   input wire logic mouse_data_pin_in, // mouse data pin level
   output logic mouse_data_pin_out, // mouse data pin drive value
   output logic mouse_data_pin_oe_n, // mouse data pin pull-down, low drives
   output logic test_input_a, // keyboard clock level to core
   output logic test_input_b, // mouse clock level to core
   output logic in_port_bit_a, // keyboard data level to core
   output logic in_port_bit_b // mouse data level to core
);
   localparam int NSYNC = 16;

   // synchronisers for everything that arrives from pins
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic rd_d;
   logic wr_d;
   logic host_rd_end;
   logic host_wr_end;
   logic s_sel_n;
   logic s_a2;
   logic s_rd_n;
   logic s_wr_n;
   logic [7:0] s_wdata;

   // flags and registers
   logic flag_mode;
   logic out_buf_full;
   logic cmd_data;
   logic [7:0] user_bits;
   logic [7:0] out_buffer;
   logic [7:0] host_status;
   kbhp_pkg::kbhp_pwr_e pwr;
   logic rst_d;

   // input buffer path
   logic push_valid;
   logic push_ready;
   logic in_buf_full;
   logic [BUF_W-1:0] head;

   // the buffer word is one byte plus its command/data mark
   if (BUF_W != kbhp_pkg::DATA_W + 1) begin : g_bad_buf_w
      $error("kbhp_host_port: BUF_W must be DATA_W+1");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_a <= '1;
         sync_b <= '1;
      end else begin
         sync_a <= {host_sel_n, host_a2, host_rd_n, host_wr_n, host_wdata,
                    kbd_clk_pin_in, kbd_data_pin_in, mouse_clk_pin_in, mouse_data_pin_in};
         sync_b <= sync_a;
      end
   end

   assign s_sel_n = sync_b[15];
   assign s_a2 = sync_b[14];
   assign s_rd_n = sync_b[13];
   assign s_wr_n = sync_b[12];
   assign s_wdata = sync_b[11:4];

   // strobe edges; a transfer is taken as its strobe is released
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_d <= 1'b0;
         wr_d <= 1'b0;
      end else begin
         rd_d <= ~s_rd_n & ~s_sel_n;
         wr_d <= ~s_wr_n & ~s_sel_n;
      end
   end

   assign host_rd_end = rd_d & (s_rd_n | s_sel_n);
   assign host_wr_end = wr_d & (s_wr_n | s_sel_n);

   // pin levels back to the core
   always_ff @(posedge clk) begin
      if (rst) begin
         test_input_a <= 1'b1;
         in_port_bit_a <= 1'b1;
         test_input_b <= 1'b1;
         in_port_bit_b <= 1'b1;
      end else begin
         test_input_a <= sync_b[3];
         in_port_bit_a <= sync_b[2];
         test_input_b <= sync_b[1];
         in_port_bit_b <= sync_b[0];
      end
   end

   // the flag mode, once entered, holds until reset
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_mode <= 1'b0;
      end else if (core_en_flags) begin
         flag_mode <= 1'b1;
      end
   end

   // host writes enter a two-entry buffer, byte plus its command/data mark
   assign push_valid = host_wr_end;

   kbhp_pair_buf #(
      .W(BUF_W)
   ) u_in_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data({s_a2, s_wdata}),
      .out_valid(in_buf_full),
      .out_ready(core_data_rd),
      .out_data(head)
   );

   assign core_input_buffer = head[7:0];

   // command/data follows address line 2 of each accepted host write
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_data <= kbhp_pkg::CD_DATA;
      end else if (host_wr_end && push_ready) begin
         cmd_data <= s_a2 ? kbhp_pkg::CD_CMD : kbhp_pkg::CD_DATA;
      end
   end

   // output buffer: set by core write wins over a host read in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         out_buf_full <= 1'b0;
      end else if (core_data_wr) begin
         out_buf_full <= 1'b1;
      end else if (host_rd_end && !s_a2) begin
         out_buf_full <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (core_data_wr) begin
         out_buffer <= core_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         user_bits <= kbhp_pkg::STS_RESET;
      end else if (core_sts_wr) begin
         user_bits <= core_wdata & kbhp_pkg::STS_UD_MASK;
      end
   end

   always_comb begin
      host_status = user_bits;
      host_status[kbhp_pkg::STS_OBF_BIT] = out_buf_full;
      host_status[kbhp_pkg::STS_IBF_BIT] = in_buf_full;
      host_status[kbhp_pkg::STS_CD_BIT] = cmd_data;
   end

   assign core_status = host_status;

   // host read data: status at the command port, output buffer at the data port
   always_ff @(posedge clk) begin
      if (rst) begin
         host_rdata <= 8'h00;
         host_rdata_oe_n <= 1'b1;
      end else begin
         host_rdata <= s_a2 ? host_status : out_buffer;
         host_rdata_oe_n <= s_rd_n | s_sel_n;
      end
   end

   // interrupt outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         kbd_irq_out <= 1'b0;
         aux_irq_out <= 1'b0;
      end else if (flag_mode) begin
         kbd_irq_out <= core_port2[kbhp_pkg::P_KBD_IRQ] & out_buf_full;
         aux_irq_out <= core_port2[kbhp_pkg::P_AUX_IRQ] & ~in_buf_full;
      end else begin
         kbd_irq_out <= core_port2[kbhp_pkg::P_KBD_IRQ];
         aux_irq_out <= core_port2[kbhp_pkg::P_AUX_IRQ];
      end
   end

   // the core has just these two interrupt sources
   assign core_irq_ibf = in_buf_full & ibf_irq_en;
   assign core_irq_tmr = tmr_overflow & tmr_irq_en;

   // general pin and open-drain pins
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_line_gate <= 1'b0;
         general_out_pin <= 1'b0;
         kbd_clk_pin_oe_n <= 1'b1;
         kbd_data_pin_oe_n <= 1'b1;
         mouse_clk_pin_oe_n <= 1'b1;
         mouse_data_pin_oe_n <= 1'b1;
      end else begin
         addr_line_gate <= core_port2[kbhp_pkg::P_ADDR_GATE];
         general_out_pin <= gp_route_gate ? core_port2[kbhp_pkg::P_ADDR_GATE]
                                          : gp_user_level;
         // a port bit of one pulls the pin low, zero releases it
         kbd_clk_pin_oe_n <= ~core_port2[kbhp_pkg::P_KBD_CLK];
         kbd_data_pin_oe_n <= ~core_port2[kbhp_pkg::P_KBD_DATA];
         mouse_clk_pin_oe_n <= ~core_port2[kbhp_pkg::P_MOUSE_CLK];
         mouse_data_pin_oe_n <= ~core_port2[kbhp_pkg::P_MOUSE_DATA];
      end
   end

   assign kbd_clk_pin_out = 1'b0;
   assign kbd_data_pin_out = 1'b0;
   assign mouse_clk_pin_out = 1'b0;
   assign mouse_data_pin_out = 1'b0;

   // power-down: reset always leaves it, an accepted host write also does
   always_ff @(posedge clk) begin
      if (rst) begin
         pwr <= kbhp_pkg::PWR_RUN;
         wake_call <= 1'b0;
         wake_next <= 1'b0;
      end else begin
         wake_call <= 1'b0;
         wake_next <= 1'b0;
         case (pwr)
            kbhp_pkg::PWR_RUN: begin
               if (core_stop) begin
                  pwr <= kbhp_pkg::PWR_HARD;
               end else if (core_halt) begin
                  pwr <= kbhp_pkg::PWR_SOFT;
               end
            end
            kbhp_pkg::PWR_SOFT, kbhp_pkg::PWR_HARD: begin
               if (push_valid && push_ready) begin
                  pwr <= kbhp_pkg::PWR_RUN;
                  wake_call <= ibf_irq_en;
                  wake_next <= ~ibf_irq_en;
               end
            end
            default: begin
               pwr <= kbhp_pkg::PWR_RUN;
            end
         endcase
      end
   end

   assign alu_clk_en = (pwr == kbhp_pkg::PWR_RUN);
   assign osc_en = (pwr != kbhp_pkg::PWR_HARD);

   // restart pulse on the first cycle after reset is released
   always_ff @(posedge clk) begin
      rst_d <= rst;
   end

   assign core_restart = rst_d & ~rst;
   assign core_start_addr = kbhp_pkg::RESET_START_ADDR;

   // checks
   AST_KBD_IRQ_OUT_FLAG: assert property (@(posedge clk) disable iff (rst)
      flag_mode && core_port2[kbhp_pkg::P_KBD_IRQ] |=> kbd_irq_out == $past(out_buf_full))
      else $error("keyboard irq does not follow OUT_BUF_FULL in flag mode");

   AST_KBD_IRQ_OUT_LOW: assert property (@(posedge clk) disable iff (rst)
      flag_mode && !core_port2[kbhp_pkg::P_KBD_IRQ] |=> !kbd_irq_out)
      else $error("keyboard irq not held low with port bit clear");

   AST_KBD_IRQ_OUT_DIRECT: assert property (@(posedge clk) disable iff (rst)
      !flag_mode |=> kbd_irq_out == $past(core_port2[kbhp_pkg::P_KBD_IRQ]))
      else $error("keyboard irq does not follow port bit");

   AST_AUX_IRQ_OUT_FLAG: assert property (@(posedge clk) disable iff (rst)
      flag_mode && core_port2[kbhp_pkg::P_AUX_IRQ] |=> aux_irq_out == !$past(in_buf_full))
      else $error("aux irq is not inverted IN_BUF_FULL");

   AST_AUX_IRQ_OUT_DIRECT: assert property (@(posedge clk) disable iff (rst)
      !flag_mode |=> aux_irq_out == $past(core_port2[kbhp_pkg::P_AUX_IRQ]))
      else $error("aux irq does not follow port bit");

   AST_OBF_SET: assert property (@(posedge clk) disable iff (rst)
      core_data_wr |=> out_buf_full && out_buffer == $past(core_wdata))
      else $error("core data write did not load output buffer");

   AST_OBF_CLR: assert property (@(posedge clk) disable iff (rst)
      host_rd_end && !s_a2 && !core_data_wr |=> !out_buf_full)
      else $error("host data read did not clear OUT_BUF_FULL");

   AST_CD_CMD: assert property (@(posedge clk) disable iff (rst)
      host_wr_end && push_ready |=> cmd_data == $past(s_a2) && in_buf_full)
      else $error("host write did not set C/D and IN_BUF_FULL");

   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
      flag_mode |=> flag_mode)
      else $error("flag mode dropped without reset");

   AST_HALT_WAKE: assert property (@(posedge clk) disable iff (rst)
      pwr != kbhp_pkg::PWR_RUN && push_valid && push_ready
      |=> alu_clk_en && (wake_call == $past(ibf_irq_en)) && (wake_next != wake_call))
      else $error("host write did not wake the core correctly");

   AST_STOP_OSC: assert property (@(posedge clk) disable iff (rst)
      pwr == kbhp_pkg::PWR_RUN && core_stop |=> !osc_en && !alu_clk_en)
      else $error("stop did not halt the oscillator");

   AST_RESET_CLR: assert property (@(posedge clk)
      rst |=> host_status == kbhp_pkg::STS_RESET && !kbd_irq_out)
      else $error("status not cleared by reset");
endmodule : kbhp_host_port
`default_nettype wire

// *** common/kbhp_pkg.sv ***
// constants for the keyboard controller host port
package kbhp_pkg;
   localparam int DATA_W = 8;
   // host port addresses, told apart by address line 2
   localparam logic [7:0] HOST_DATA_PORT = 8'h60;
   localparam logic [7:0] HOST_CMD_PORT = 8'h64;
   // host status field positions
   localparam int STS_OBF_BIT = 0;
   localparam int STS_IBF_BIT = 1;
   localparam int STS_CD_BIT = 3;
   localparam logic [7:0] STS_UD_MASK = 8'hF4;
   localparam logic [7:0] STS_RESET = 8'h00;
   // command/data encodings of the status bit
   localparam logic CD_DATA = 1'b0;
   localparam logic CD_CMD = 1'b1;
   // core port 2 bit positions
   localparam int P_ADDR_GATE = 1;
   localparam int P_MOUSE_DATA = 2;
   localparam int P_MOUSE_CLK = 3;
   localparam int P_KBD_IRQ = 4;
   localparam int P_AUX_IRQ = 5;
   localparam int P_KBD_CLK = 6;
   localparam int P_KBD_DATA = 7;
   // core restarts from this program address
   localparam logic [10:0] RESET_START_ADDR = 11'h000;
   // least reset pulse, in core clock periods
   localparam int RESET_MIN_CYC = 24;
   // input synchroniser depth
   localparam int SYNC_STAGES = 2;
   // power state of the core
   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_SOFT = 3'b010,
      PWR_HARD = 3'b100
   } kbhp_pwr_e;
endpackage : kbhp_pkg

// *** hw/kbhp_pair_buf.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module kbhp_pair_buf #(
   parameter int W = 8
) (
   input wire logic clk, // clock
   input wire logic rst, // synchronous reset
   input wire logic in_valid, // word offered
   output logic in_ready, // room for a word
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid, // word held
   input wire logic out_ready, // word taken
   output logic [W-1:0] out_data // oldest word, registered
);
   logic [1:0] count;
   logic [W-1:0] second;
   logic push;
   logic pop;

   // refuse a width the buffer cannot hold
   if (W < 1) begin : g_bad_w
      $error("kbhp_pair_buf: W must be at least 1");
   end

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 2'h0;
      end else if (push && !pop) begin
         count <= count + 2'h1;
      end else if (pop && !push) begin
         count <= count - 2'h1;
      end
   end

   // data words carry no reset value
   always_ff @(posedge clk) begin
      if (push && pop) begin
         if (count == 2'h1) begin
            out_data <= in_data;
         end else begin
            out_data <= second;
            second <= in_data;
         end
      end else if (pop) begin
         out_data <= second;
      end else if (push) begin
         if (count == 2'h0) begin
            out_data <= in_data;
         end else begin
            second <= in_data;
         end
      end
   end
endmodule : kbhp_pair_buf
`default_nettype wire

// *** test/kbhp_host_model.sv ***
// host processor model: strobed reads and writes of the two keyboard ports
`timescale 1ns/10ps
`default_nettype none
module kbhp_host_model (
   input wire logic clk, // clock
   output logic host_sel_n, // port select
   output logic host_a2, // address line 2
   output logic host_rd_n, // read strobe
   output logic host_wr_n, // write strobe
   output logic [7:0] host_wdata, // write data
   input wire logic [7:0] host_rdata, // read data
   output logic rd_done, // one cycle after a read
   output logic [7:0] rd_byte // byte taken by the read
);
   initial begin
      host_sel_n = 1'b1;
      host_a2 = 1'b0;
      host_rd_n = 1'b1;
      host_wr_n = 1'b1;
      host_wdata = 8'hA5;
      rd_done = 1'b0;
      rd_byte = 8'h00;
   end
   // strobe held five clocks and select four more, so the two-flop sync sees both whole
   task automatic host_cycle(input logic a2, input logic wr, input logic [7:0] d);
      @(negedge clk);
      host_sel_n = 1'b0;
      host_a2 = a2;
      host_wdata = d;
      host_wr_n = ~wr;
      host_rd_n = wr;
      repeat (5) @(negedge clk);
      rd_byte = host_rdata;
      rd_done = ~wr;
      host_wr_n = 1'b1;
      host_rd_n = 1'b1;
      @(negedge clk);
      rd_done = 1'b0;
      repeat (3) @(negedge clk);
      host_sel_n = 1'b1;
      host_wdata = ~d;
   endtask : host_cycle
endmodule : kbhp_host_model
`default_nettype wire

// *** test/kbhp_host_port_test.sv ***
// self-checking bench for the keyboard controller host port
`timescale 1ns/10ps
`default_nettype none
module kbhp_host_port_test;
   logic clk, rst, host_sel_n, host_a2, host_rd_n, host_wr_n, host_rdata_oe_n;
   logic [7:0] host_wdata, host_rdata, core_wdata, core_input_buffer, core_status, core_port2;
   logic core_data_wr, core_data_rd, core_sts_wr, core_en_flags, core_halt, core_stop;
   logic ibf_irq_en, tmr_irq_en, tmr_overflow, core_irq_ibf, core_irq_tmr, kbd_irq_out;
   logic aux_irq_out, alu_clk_en, osc_en, wake_call, wake_next, core_restart;
   logic [10:0] core_start_addr;
   logic gp_route_gate, gp_user_level, general_out_pin, addr_line_gate;
   logic kbd_clk_pin_in, kbd_clk_pin_out, kbd_clk_pin_oe_n;
   logic kbd_data_pin_in, kbd_data_pin_out, kbd_data_pin_oe_n;
   logic mouse_clk_pin_in, mouse_clk_pin_out, mouse_clk_pin_oe_n;
   logic mouse_data_pin_in, mouse_data_pin_out, mouse_data_pin_oe_n;
   logic test_input_a, test_input_b, in_port_bit_a, in_port_bit_b, rd_done;
   logic [7:0] rd_byte, exp_b, d0, d1, d2, p;
   logic [3:0] ext; // far-end level of kbd_clk_pin, kbd_data_pin, mclk, mouse_data_pin
   logic [7:0] exp_q[$];
   int miscompares = 0, cmp_count = 0, cycles = 0, n_call = 0, n_next = 0, n_rst = 0;
   integer seed;

   // open-drain lines: low while the block pulls, else the far end's level
   assign kbd_clk_pin_in = kbd_clk_pin_oe_n ? ext[0] : kbd_clk_pin_out;
   assign kbd_data_pin_in = kbd_data_pin_oe_n ? ext[1] : kbd_data_pin_out;
   assign mouse_clk_pin_in = mouse_clk_pin_oe_n ? ext[2] : mouse_clk_pin_out;
   assign mouse_data_pin_in = mouse_data_pin_oe_n ? ext[3] : mouse_data_pin_out;

   kbhp_host_port #(.BUF_W(9)) i_dut (.*);
   kbhp_host_model i_host (
      .clk(clk),
      .host_sel_n(host_sel_n),
      .host_a2(host_a2),
      .host_rd_n(host_rd_n),
      .host_wr_n(host_wr_n),
      .host_wdata(host_wdata),
      .host_rdata(host_rdata),
      .rd_done(rd_done),
      .rd_byte(rd_byte)
   );

   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic end_of_test();
      $display("%0d comparisons, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit

   // read results come back from the host model and meet the oldest note
   always @(posedge clk) begin
      cycles++;
      if (wake_call) n_call++;
      if (wake_next) n_next++;
      if (core_restart) n_rst++;
      if (rd_done) begin
         exp_b = exp_q.pop_front();
         chk_val(rd_byte, exp_b, "host read");
         chk_bit(host_rdata_oe_n, 1'b0, "read drives bus");
      end
      if (cycles == 20000) begin
         miscompares++;
         $display("[ERR] %0t run did not finish", $time);
         end_of_test();
      end
   end

   task automatic hwr(input logic a2, input logic [7:0] d);
      i_host.host_cycle(a2, 1'b1, d);
      repeat (6) @(negedge clk);
   endtask : hwr

   task automatic hrd(input logic a2, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.host_cycle(a2, 1'b0, 8'h00);
      repeat (6) @(negedge clk);
      chk_bit(host_rdata_oe_n, 1'b1, "bus released");
   endtask : hrd

   // k: 5 data write, 4 data read, 3 status write, 2 flag mode, 1 halt, 0 stop
   task automatic op(input int k);
      @(negedge clk);
      {core_data_wr, core_data_rd, core_sts_wr, core_en_flags, core_halt, core_stop} = 6'h01 << k;
      @(negedge clk);
      {core_data_wr, core_data_rd, core_sts_wr, core_en_flags, core_halt, core_stop} = 6'h00;
      repeat (3) @(negedge clk);
   endtask : op

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (kbhp_pkg::RESET_MIN_CYC) @(negedge clk);
      chk_bit(kbd_irq_out, 1'b0, "irq in reset");
      chk_val(core_status, kbhp_pkg::STS_RESET, "status in reset");
      rst = 1'b0;
      repeat (4) @(negedge clk);
   endtask : do_reset

   initial begin
      seed = 32'hAC0CF834;
      rst = 1'b1;
      {core_data_wr, core_data_rd, core_sts_wr, core_en_flags, core_halt, core_stop} = 6'h00;
      core_wdata = 8'h00;
      core_port2 = 8'h00;
      {ibf_irq_en, tmr_irq_en, tmr_overflow, gp_route_gate, gp_user_level} = 5'h00;
      ext = 4'hF;
      do_reset();
      chk_val(8'(n_rst), 8'h01, "restart pulse");
      chk_bit(core_start_addr === kbhp_pkg::RESET_START_ADDR, 1'b1, "start address");
      hrd(1'b1, kbhp_pkg::STS_RESET);
      $display("reset test done");

      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      ibf_irq_en = 1'b1;
      hwr(1'b0, d0);
      chk_val(core_status & 8'h0B, 8'h02, "data write flags");
      chk_val(core_input_buffer, d0, "head byte");
      chk_bit(core_irq_ibf, 1'b1, "ibf core irq");
      hwr(1'b1, d1);
      chk_val(core_status & 8'h0B, 8'h0A, "command write flags");
      hwr(1'b0, d2);
      chk_val(core_status & 8'h0B, 8'h0A, "write to full buffer");
      op(4);
      chk_val(core_input_buffer, d1, "second byte");
      chk_bit(core_status[1], 1'b1, "ibf while byte left");
      op(4);
      chk_bit(core_status[1], 1'b0, "ibf cleared");
      chk_bit(core_irq_ibf, 1'b0, "ibf irq cleared");
      $display("buffer test done");

      for (int i = 0; i < 4; i++) begin
         core_port2[5:4] = i[1:0];
         repeat (3) @(negedge clk);
         chk_bit(kbd_irq_out, i[0], "kbd irq from port");
         chk_bit(aux_irq_out, i[1], "aux irq from port");
      end
      core_wdata = d0;
      op(5);
      chk_val(core_status & 8'h0B, 8'h09, "obf set");
      core_wdata = 8'hFF;
      op(3);
      chk_val(core_status, 8'hFD, "user bits");
      hrd(1'b1, 8'hFD);
      hrd(1'b0, d0);
      chk_bit(core_status[0], 1'b0, "obf cleared");
      chk_bit(kbd_irq_out, 1'b1, "kbd irq left to software");
      core_wdata = 8'h00;
      op(3);
      $display("port mode test done");

      op(2);
      chk_bit(kbd_irq_out, 1'b0, "flag irq, obf clear");
      chk_bit(aux_irq_out, 1'b1, "flag aux, ibf clear");
      core_wdata = d1;
      op(5);
      chk_bit(kbd_irq_out, 1'b1, "flag irq, obf set");
      core_port2[4] = 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(kbd_irq_out, 1'b0, "port bit low");
      core_port2[4] = 1'b1;
      hwr(1'b0, d2);
      chk_bit(aux_irq_out, 1'b0, "flag aux, ibf set");
      hrd(1'b0, d1);
      chk_bit(kbd_irq_out, 1'b0, "read clears irq");
      op(4);
      chk_bit(aux_irq_out, 1'b1, "aux after core read");
      $display("flag mode test done");

      for (int i = 0; i < 16; i++) begin
         p = 8'($random(seed));
         core_port2 = {p[7:6], 2'b11, p[3:0]};
         ext = 4'($random(seed));
         {gp_route_gate, gp_user_level, tmr_irq_en, tmr_overflow} = 4'($random(seed));
         repeat (5) @(negedge clk);
         chk_bit(kbd_clk_pin_oe_n, ~p[6], "kbd_clk_pin drive");
         chk_bit(kbd_data_pin_oe_n, ~p[7], "kbd_data_pin drive");
         chk_bit(mouse_clk_pin_oe_n, ~p[3], "mclk drive");
         chk_bit(mouse_data_pin_oe_n, ~p[2], "mouse_data_pin drive");
         chk_bit(test_input_a, ext[0] & ~p[6], "kbd_clk_pin level");
         chk_bit(in_port_bit_a, ext[1] & ~p[7], "kbd_data_pin level");
         chk_bit(test_input_b, ext[2] & ~p[3], "mclk level");
         chk_bit(in_port_bit_b, ext[3] & ~p[2], "mouse_data_pin level");
         chk_bit(general_out_pin, gp_route_gate ? p[1] : gp_user_level, "general pin");
         chk_bit(addr_line_gate, p[1], "gate level");
         chk_bit(core_irq_tmr, tmr_irq_en & tmr_overflow, "timer irq");
      end
      $display("pin test done");

      ibf_irq_en = 1'b1;
      {tmr_irq_en, tmr_overflow} = 2'b11;
      op(1);
      chk_bit(alu_clk_en, 1'b0, "halt stops alu");
      chk_bit(osc_en & core_irq_tmr, 1'b1, "timer alive in halt");
      hwr(1'b0, d0);
      chk_val(8'(n_call), 8'h01, "wake with call");
      chk_bit(alu_clk_en, 1'b1, "alu runs again");
      op(4);
      ibf_irq_en = 1'b0;
      op(0);
      chk_bit(osc_en, 1'b0, "stop halts osc");
      hwr(1'b1, d1);
      chk_val(8'(n_next), 8'h01, "wake to next");
      chk_bit(osc_en, 1'b1, "osc on again");
      op(4);
      op(0);
      do_reset();
      chk_bit(osc_en & alu_clk_en, 1'b1, "reset wakes core");
      chk_val(8'(n_rst), 8'h02, "restart after wake");
      chk_bit(kbd_irq_out, 1'b1, "flag mode gone");
      $display("power test done");
      end_of_test();
   end
endmodule : kbhp_host_port_test
`default_nettype wire
